// ---- design/timer_compare_output_control.sv ----
`timescale 1ns/100ps
module timer_compare_output_control
	import timer_wave_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [APB_DW-1:0] pwdata,
	output logic      [APB_DW-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Compare outputs
	output logic                   compare_out_a,
	output logic                   compare_out_a_sel,
	output logic                   compare_out_b,
	output logic                   compare_out_b_sel,
	// Interrupt
	output logic                   irq
);

	// Control registers
	logic [7:0]        ctrl_a_ff;
	logic [7:0]        ctrl_b_ff;
	logic [EV_N-1:0]   status_ff;
	logic [EV_N-1:0]   enable_ff;
	logic [APB_DW-1:0] prdata_ff;

	// Counter state
	logic [7:0]        cnt_ff;
	logic              dir_down_ff;

	// Per channel compare state
	logic [7:0]        cmp_buf [2];
	logic [7:0]        cmp_act [2];
	logic [1:0]        ch_match;
	logic [1:0]        ch_wave;
	logic [1:0]        ch_sel;

	// Decoded fields
	logic [1:0]        output_a_action;
	logic [1:0]        output_b_action;
	logic [1:0]        waveform_mode_lo;
	logic              waveform_mode_hi;
	logic [2:0]        waveform_mode_sel;
	logic              run;
	mode_s             mode;

	// Counter events
	logic [7:0]        top;
	logic              running;
	logic              at_top;
	logic              at_bottom;
	logic              top_evt;
	logic              load_cmp;
	logic              ovf_evt;
	logic [EV_N-1:0]   events;

	// Bus decode
	logic              wr_en;
	logic              rd_setup;
	logic              mapped;
	logic [APB_DW-1:0] rd_data;
	logic [EV_N-1:0]   clr_bits;

	// Mode table
	function automatic mode_s decode_mode(input logic [2:0] m);
		mode_s d;
		d = '0;
		case (m)
			MODE_NORMAL: begin
				d.upd_now = 1'b1;
				d.ovf_max = 1'b1;
			end
			MODE_PC_FULL: begin
				d.pwm        = 1'b1;
				d.phase      = 1'b1;
				d.upd_top    = 1'b1;
				d.ovf_bottom = 1'b1;
			end
			MODE_CLEAR_MATCH: begin
				d.top_is_a = 1'b1;
				d.upd_now  = 1'b1;
				d.ovf_max  = 1'b1;
			end
			MODE_FAST_FULL: begin
				d.pwm        = 1'b1;
				d.fast       = 1'b1;
				d.upd_bottom = 1'b1;
				d.ovf_max    = 1'b1;
			end
			MODE_PC_CMPA: begin
				d.pwm        = 1'b1;
				d.phase      = 1'b1;
				d.top_is_a   = 1'b1;
				d.upd_top    = 1'b1;
				d.ovf_bottom = 1'b1;
			end
			MODE_FAST_CMPA: begin
				d.pwm        = 1'b1;
				d.fast       = 1'b1;
				d.top_is_a   = 1'b1;
				d.upd_bottom = 1'b1;
				d.ovf_top    = 1'b1;
			end
			default: begin
				// Codes 4 and 6: counter held, buffers pass through
				d.reserved = 1'b1;
				d.upd_now  = 1'b1;
			end
		endcase
		return d;
	endfunction

	// Field extraction
	assign output_a_action   = ctrl_a_ff[ACT_A_LSB +: 2];
	assign output_b_action   = ctrl_a_ff[ACT_B_LSB +: 2];
	assign waveform_mode_lo  = ctrl_a_ff[WGM_LO_LSB +: 2];
	assign waveform_mode_hi  = ctrl_b_ff[WGM_HI_BIT];
	assign run               = ctrl_b_ff[RUN_BIT];
	assign waveform_mode_sel = {waveform_mode_hi, waveform_mode_lo};
	assign mode              = decode_mode(waveform_mode_sel);

	// TOP source and counter position
	assign top       = mode.top_is_a ? cmp_act[0] : CNT_MAX;
	assign running   = run && !mode.reserved;
	assign at_top    = (cnt_ff == top);
	assign at_bottom = (cnt_ff == CNT_BOTTOM);
	assign top_evt   = running && at_top;

	// Compare buffers load per mode; always while stopped
	always_comb begin
		load_cmp = !running || mode.upd_now;
		if (mode.upd_top && top_evt) begin
			load_cmp = 1'b1;
		end
		if (mode.upd_bottom && top_evt) begin
			load_cmp = 1'b1;
		end
	end

	// Overflow event per mode
	always_comb begin
		ovf_evt = 1'b0;
		if (running) begin
			if (mode.ovf_max && cnt_ff == CNT_MAX) begin
				ovf_evt = 1'b1;
			end
			if (mode.ovf_bottom && at_bottom && dir_down_ff) begin
				ovf_evt = 1'b1;
			end
			if (mode.ovf_top && at_top) begin
				ovf_evt = 1'b1;
			end
		end
	end

	assign events = {ch_match[1], ch_match[0], ovf_evt};

	// Bus strobes; single-cycle access phase
	assign wr_en    = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign clr_bits = (wr_en && paddr == ADDR_CLEAR) ?
		pwdata[EV_N-1:0] : '0;

	// Address map check
	always_comb begin
		case (paddr)
			ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CMP_A, ADDR_CMP_B,
			ADDR_COUNT, ADDR_STATUS, ADDR_CLEAR,
			ADDR_ENABLE: mapped = 1'b1;
			default:     mapped = 1'b0;
		endcase
	end

	// Read mux
	always_comb begin
		rd_data = '0;
		case (paddr)
			ADDR_CTRL_A: rd_data[7:0] = ctrl_a_ff & CTRL_A_MASK;
			ADDR_CTRL_B: rd_data[7:0] = ctrl_b_ff & CTRL_B_MASK;
			ADDR_CMP_A:  rd_data[7:0] = cmp_buf[0];
			ADDR_CMP_B:  rd_data[7:0] = cmp_buf[1];
			ADDR_COUNT:  rd_data[7:0] = cnt_ff;
			ADDR_STATUS: rd_data[EV_N-1:0] = status_ff;
			ADDR_ENABLE: rd_data[EV_N-1:0] = enable_ff;
			default:     rd_data = '0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_ff;

	// Read data captured in the setup cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata_ff <= '0;
		end else if (rd_setup) begin
			prdata_ff <= rd_data;
		end
	end

	// First control register; reserved bits never stored
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_a_ff <= CTRL_RESET;
		end else if (wr_en && paddr == ADDR_CTRL_A) begin
			ctrl_a_ff <= pwdata[7:0] & CTRL_A_MASK;
		end
	end

	// Second control register: high mode bit and run
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_b_ff <= CTRL_RESET;
		end else if (wr_en && paddr == ADDR_CTRL_B) begin
			ctrl_b_ff <= pwdata[7:0] & CTRL_B_MASK;
		end
	end

	// Interrupt enable register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			enable_ff <= IRQ_RESET;
		end else if (wr_en && paddr == ADDR_ENABLE) begin
			enable_ff <= pwdata[EV_N-1:0];
		end
	end

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_ff <= IRQ_RESET;
		end else begin
			status_ff <= (status_ff & ~clr_bits) | events;
		end
	end

	assign irq = |(status_ff & enable_ff);

	// Count direction, only used in phase correct modes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dir_down_ff <= 1'b0;
		end else if (!mode.phase) begin
			dir_down_ff <= 1'b0;
		end else if (running) begin
			if (!dir_down_ff && at_top) begin
				dir_down_ff <= 1'b1;
			end else if (dir_down_ff && at_bottom) begin
				dir_down_ff <= 1'b0;
			end
		end
	end

	// Counter: single slope wraps at TOP, dual slope turns at TOP
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= CNT_BOTTOM;
		end else if (running) begin
			if (mode.phase) begin
				if (!dir_down_ff) begin
					if (!at_top) begin
						cnt_ff <= cnt_ff + 8'h01;
					end else if (!at_bottom) begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end else begin
					if (!at_bottom) begin
						cnt_ff <= cnt_ff - 8'h01;
					end else if (!at_top) begin
						cnt_ff <= cnt_ff + 8'h01;
					end
				end
			end else if (at_top) begin
				cnt_ff <= CNT_BOTTOM;
			end else begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end

	// Compare channels: buffer, active copy, match and waveform
	for (genvar g = 0; g < 2; g++) begin : g_chan
		localparam logic [7:0] CMP_ADDR = (g == 0) ? ADDR_CMP_A : ADDR_CMP_B;
		logic [7:0] buf_ff;
		logic [7:0] act_ff;
		logic [1:0] action;

		assign action     = (g == 0) ? output_a_action : output_b_action;
		assign cmp_buf[g] = buf_ff;
		assign cmp_act[g] = act_ff;
		assign ch_match[g] = running && (cnt_ff == act_ff);

		// Software side of the compare value
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				buf_ff <= CMP_RESET;
			end else if (wr_en && paddr == CMP_ADDR) begin
				buf_ff <= pwdata[7:0];
			end
		end

		// Active compare value, reloaded per mode
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				act_ff <= CMP_RESET;
			end else if (load_cmp) begin
				act_ff <= buf_ff;
			end
		end

		compare_output_unit #(
			.CHAN_A (g == 0)
		) u_unit (
			.clk        (clk),
			.rstn       (rstn),
			.action     (action),
			.mode       (mode),
			.wgm_hi     (waveform_mode_hi),
			.match      (ch_match[g]),
			.top_evt    (top_evt),
			.dir_down   (dir_down_ff),
			.cmp_is_top (act_ff == top),
			.wave_ff    (ch_wave[g]),
			.connect    (ch_sel[g])
		);
	end

	// Pin side: waveform level and takeover select per channel
	assign compare_out_a     = ch_wave[0];
	assign compare_out_a_sel = ch_sel[0];
	assign compare_out_b     = ch_wave[1];
	assign compare_out_b_sel = ch_sel[1];

endmodule

// ---- design/timer_wave_pkg.sv ----
package timer_wave_pkg;

	// Bus geometry
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL_A = 8'h24;
	localparam logic [7:0] ADDR_CTRL_B = 8'h28;
	localparam logic [7:0] ADDR_CMP_A  = 8'h2C;
	localparam logic [7:0] ADDR_CMP_B  = 8'h30;
	localparam logic [7:0] ADDR_COUNT  = 8'h34;
	localparam logic [7:0] ADDR_STATUS = 8'h38;
	localparam logic [7:0] ADDR_CLEAR  = 8'h3C;
	localparam logic [7:0] ADDR_ENABLE = 8'h40;

	// Field positions in waveform_control_a
	localparam int ACT_A_LSB   = 6;
	localparam int ACT_B_LSB   = 4;
	localparam int WGM_LO_LSB  = 0;
	localparam logic [7:0] CTRL_A_MASK = 8'hF3;

	// Field positions in waveform_control_b
	localparam int WGM_HI_BIT  = 3;
	localparam int RUN_BIT     = 0;
	localparam logic [7:0] CTRL_B_MASK = 8'h09;

	// Values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET  = 8'h00;
	localparam logic [2:0] IRQ_RESET  = 3'h0;

	// Counter limits
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hFF;

	// Status and enable bit positions
	localparam int EV_OVF     = 0;
	localparam int EV_MATCH_A = 1;
	localparam int EV_MATCH_B = 2;
	localparam int EV_N       = 3;

	// Output action codes
	localparam logic [1:0] ACT_OFF    = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;

	// Waveform mode codes
	localparam logic [2:0] MODE_NORMAL  = 3'h0;
	localparam logic [2:0] MODE_PC_FULL = 3'h1;
	localparam logic [2:0] MODE_CLEAR_MATCH = 3'h2;
	localparam logic [2:0] MODE_FAST_FULL = 3'h3;
	localparam logic [2:0] MODE_PC_CMPA = 3'h5;
	localparam logic [2:0] MODE_FAST_CMPA = 3'h7;

	// Decoded waveform mode
	typedef struct packed {
		logic pwm;
		logic fast;
		logic phase;
		logic top_is_a;
		logic reserved;
		logic upd_now;
		logic upd_top;
		logic upd_bottom;
		logic ovf_max;
		logic ovf_bottom;
		logic ovf_top;
	} mode_s;

endpackage

// ---- design/compare_output_unit.sv ----
`timescale 1ns/100ps
module compare_output_unit
	import timer_wave_pkg::*;
#(
	parameter bit CHAN_A = 1'b1
)(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Configuration
	input  wire logic [1:0] action,
	input  wire mode_s      mode,
	input  wire logic       wgm_hi,
	// Counter events
	input  wire logic       match,
	input  wire logic       top_evt,
	input  wire logic       dir_down,
	input  wire logic       cmp_is_top,
	// Waveform
	output logic            wave_ff,
	output logic            connect
);

	logic nxt_wave;

	// Pin takeover; PWM code 1 only connects on channel A with mode bit
	always_comb begin
		connect = (action != ACT_OFF);
		if (mode.pwm && action == ACT_TOGGLE && !(CHAN_A && wgm_hi)) begin
			connect = 1'b0;
		end
	end

	// Next waveform level from action, mode and counter events
	always_comb begin
		nxt_wave = wave_ff;
		if (!mode.pwm) begin
			if (match) begin
				case (action)
					ACT_TOGGLE: nxt_wave = ~wave_ff;
					ACT_CLEAR:  nxt_wave = 1'b0;
					ACT_SET:    nxt_wave = 1'b1;
					default:    nxt_wave = wave_ff;
				endcase
			end
		end else if (action == ACT_TOGGLE) begin
			if (CHAN_A && wgm_hi && match) begin
				nxt_wave = ~wave_ff;
			end
		end else if (action[1]) begin
			if (cmp_is_top) begin
				// Match ignored, level forced when the counter is at TOP
				if (top_evt) begin
					nxt_wave = ~action[0];
				end
			end else if (mode.fast) begin
				if (match) begin
					nxt_wave = action[0];
				end else if (top_evt) begin
					nxt_wave = ~action[0];
				end
			end else if (match) begin
				nxt_wave = dir_down ? ~action[0] : action[0];
			end
		end
	end

	// Waveform flop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wave_ff <= 1'b0;
		end else begin
			wave_ff <= nxt_wave;
		end
	end

endmodule

// ---- sim/timer_compare_output_control_monitor.sv ----
`timescale 1ns/100ps
module timer_compare_output_control_monitor
	import timer_wave_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rstn,
	// APB slave
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [APB_DW-1:0] pwdata,
	input wire logic [APB_DW-1:0] prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Compare outputs and interrupt
	input wire logic              compare_out_a,
	input wire logic              compare_out_a_sel,
	input wire logic              compare_out_b,
	input wire logic              compare_out_b_sel,
	input wire logic              irq
);
	logic [7:0] ctl_a_ff;
	logic [7:0] ctl_b_ff;
	logic [7:0] cmp_a_ff;
	logic [2:0] en_ff;
	logic [9:0] age_ff;
	logic [2:0] md;
	logic [1:0] aa;
	logic [1:0] ab;
	logic       run;
	logic       old;
	logic       top_a;
	logic       mapped;
	logic       exp_a;
	logic       exp_b;

	// Shadow copy of what software wrote
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctl_a_ff <= CTRL_RESET;
			ctl_b_ff <= CTRL_RESET;
			cmp_a_ff <= CMP_RESET;
			en_ff <= IRQ_RESET;
		end else if (psel && penable && pwrite && pready) begin
			if (paddr == ADDR_CTRL_A) ctl_a_ff <= pwdata[7:0];
			if (paddr == ADDR_CTRL_B) ctl_b_ff <= pwdata[7:0];
			if (paddr == ADDR_CMP_A) cmp_a_ff <= pwdata[7:0];
			if (paddr == ADDR_ENABLE) en_ff <= pwdata[2:0];
		end
	end

	// Cycles since the bus was last used, saturating
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			age_ff <= '0;
		else if (psel)
			age_ff <= '0;
		else if (age_ff != 10'h3FF)
			age_ff <= age_ff + 10'h001;
	end

	// Decoded configuration and expected pin selects
	assign md = {ctl_b_ff[WGM_HI_BIT], ctl_a_ff[1:0]};
	assign aa = ctl_a_ff[7:6];
	assign ab = ctl_a_ff[5:4];
	assign run = ctl_b_ff[RUN_BIT];
	assign old = age_ff > 10'h258;
	assign top_a = md[2] || cmp_a_ff == CNT_MAX;
	assign mapped = paddr >= ADDR_CTRL_A && paddr <= ADDR_ENABLE
		&& paddr[1:0] == 2'h0;
	assign exp_a = aa != ACT_OFF && !(md[0] && aa == ACT_TOGGLE && !md[2]);
	assign exp_b = ab != ACT_OFF && !(md[0] && ab == ACT_TOGGLE);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_access;
		psel && penable;
	endsequence
	sequence s_bad_addr;
		s_access ##0 !mapped;
	endsequence
	sequence s_ctrl_rd;
		s_access ##0 (!pwrite && paddr == ADDR_CTRL_A);
	endsequence
	// Stopped for three sampled cycles
	sequence s_stopped;
		!run ##1 !run ##1 !run;
	endsequence
	// Running and left alone long enough for a full period
	sequence s_settled;
		run && old;
	endsequence

	a_ready_high: assert property (pready)
		else $error("pready low");
	a_sel_a_map: assert property (compare_out_a_sel == exp_a)
		else $error("compare_out_a_sel wrong");
	a_sel_b_map: assert property (compare_out_b_sel == exp_b)
		else $error("compare_out_b_sel wrong");
	a_bad_addr: assert property (s_bad_addr |-> pslverr && prdata == '0)
		else $error("unmapped access not refused");
	a_ctrl_rsvd: assert property (s_ctrl_rd |->
		prdata[3:2] == 2'h0 && prdata[31:8] == '0)
		else $error("reserved control bits not zero");
	a_stop_still: assert property (s_stopped |->
		$stable(compare_out_a) && $stable(compare_out_b))
		else $error("output moved while stopped");
	a_nonpwm_lvl: assert property (s_settled ##0
		(!md[0] && !md[2] && aa[1]) |-> compare_out_a == aa[0])
		else $error("non-PWM clear or set level wrong");
	a_fast_top: assert property (s_settled ##0
		(md[0] && md[1] && aa[1] && top_a) |-> compare_out_a == !aa[0])
		else $error("fast PWM top case level wrong");
	a_phase_top: assert property (s_settled ##0
		(md[0] && !md[1] && aa[1] && top_a) |-> compare_out_a == !aa[0])
		else $error("phase PWM top case level wrong");
	a_irq_masked: assert property (en_ff == 3'h0 |-> !irq)
		else $error("irq high with nothing enabled");
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench
	import timer_wave_pkg::*;
;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [APB_DW-1:0] pwdata = '0;
	logic [APB_DW-1:0] prdata;
	logic [APB_DW-1:0] rd;
	logic              pready, pslverr, irq, er;
	logic              co_a, co_a_sel, co_b, co_b_sel;
	int                bad_count = 0;
	int                comparisons = 0;
	int                modes[6] = '{0, 1, 2, 3, 5, 7};
	int                t;

	// 250 MHz clock
	always #2 clk = ~clk;

	timer_compare_output_control dut_u (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .compare_out_a(co_a),
		.compare_out_a_sel(co_a_sel), .compare_out_b(co_b),
		.compare_out_b_sel(co_b_sel), .irq(irq));

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask

	// One APB transfer; returns just after the completing edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Access phase holds until pready is seen high at an edge
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(string n, logic [7:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(n, e, rd);
	endtask

	// Window of one steady pattern, and its high cycles
	function automatic int win(int m, int act, int top);
		if (m[0] == 0 || act == 1) return 2 * (top + 1);
		if (m[1]) return top + 1;
		return 2 * top;
	endfunction

	function automatic int hi(int m, int act, int c, int top);
		int w;
		w = win(m, act, top);
		if (act == 1) return w / 2;
		if (m[0] == 0) return (act == 3) ? w : 0;
		if (act == 3) return w - hi(m, 2, c, top);
		return m[1] ? c + 1 : 2 * c;
	endfunction

	// Configure, let it settle, count high cycles on both pins
	task automatic run_case(int m, int aa, int ab, int ca, int cb);
		int top, wa, wb;
		integer ha, hb;
		top = (m == 2 || m == 5 || m == 7) ? ca : 255;
		wr(ADDR_CMP_A, ca);
		wr(ADDR_CMP_B, cb);
		wr(ADDR_CTRL_A, {aa[1:0], ab[1:0], 2'b00, m[1:0]});
		wr(ADDR_CTRL_B, {m[2], 3'b001});
		repeat (1100) @(posedge clk);
		wa = win(m, aa, top);
		wb = win(m, ab, top);
		ha = 0;
		hb = 0;
		for (int i = 0; i < wa || i < wb; i++) begin
			@(posedge clk);
			#1;
			if (i < wa) ha += co_a;
			if (i < wb) hb += co_b;
		end
		check("high cycles a", hi(m, aa, ca, top), ha);
		check("high cycles b", hi(m, ab, cb, top), hb);
		$display("waveform case mode %0d done", m);
	endtask

	// Watchdog sized well above the expected 13k cycles
	initial begin
		#200000;
		bad_count++;
		conclude();
	end

	initial begin
		void'($urandom(66138));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rdchk("ctrl_a reset", ADDR_CTRL_A, 0);
		rdchk("ctrl_b reset", ADDR_CTRL_B, 0);
		check("pin a reset", 0, {co_a, co_a_sel, co_b, co_b_sel});
		wr(ADDR_CTRL_A, 32'hFFFF_FFFF);
		rdchk("ctrl_a bits", ADDR_CTRL_A, CTRL_A_MASK);
		wr(ADDR_CTRL_B, 32'hFFFF_FFFE);
		rdchk("ctrl_b bits", ADDR_CTRL_B, 32'h0000_0008);
		apb(1'b0, 8'h44, 32'h0000_0000);
		check("unmapped err", 1, er);
		check("unmapped data", 0, rd);
		$display("register test done");
		// Takeover selects only; the pin direction bit sits outside
		foreach (modes[k]) for (int a = 0; a < 4; a++) begin
			wr(ADDR_CTRL_A, {a[1:0], a[1:0], 2'b00, modes[k][1:0]});
			wr(ADDR_CTRL_B, {modes[k][2], 3'b000});
			check("sel a", a != 0 && !(modes[k][0] && a == 1
				&& !modes[k][2]), co_a_sel);
			check("sel b", a != 0 && !(modes[k][0] && a == 1), co_b_sel);
		end
		$display("select test done");
		wr(ADDR_CTRL_A, 32'h0000_0002);
		wr(ADDR_CLEAR, 32'h0000_0007);
		wr(ADDR_CMP_A, 20);
		wr(ADDR_CMP_B, 200);
		wr(ADDR_CTRL_B, 32'h0000_0001);
		repeat (300) @(posedge clk);
		wr(ADDR_CTRL_B, 32'h0000_0000);
		rdchk("status ctc", ADDR_STATUS, 32'h0000_0002);
		wr(ADDR_ENABLE, 32'h0000_0004);
		check("irq masked", 0, irq);
		wr(ADDR_ENABLE, 32'h0000_0002);
		check("irq raised", 1, irq);
		wr(ADDR_CLEAR, 32'h0000_0002);
		check("irq cleared", 0, irq);
		$display("interrupt test done");
		// Normal mode passes both compares and MAX within 300 cycles
		wr(ADDR_CLEAR, 32'h0000_0007);
		wr(ADDR_CTRL_A, 32'h0000_0000);
		wr(ADDR_CTRL_B, 32'h0000_0001);
		repeat (300) @(posedge clk);
		// Reserved mode 4 with run set: counter held, no events
		wr(ADDR_CTRL_B, 32'h0000_0009);
		rdchk("status normal", ADDR_STATUS, 32'h0000_0007);
		wr(ADDR_CLEAR, 32'h0000_0007);
		repeat (50) @(posedge clk);
		rdchk("status reserved", ADDR_STATUS, 32'h0000_0000);
		$display("overflow test done");
		t = 16 + $urandom % 48;
		run_case(2, 1, 2, t, $urandom % t);
		run_case(2, 3, 1, t, $urandom % t);
		run_case(0, 2, 3, $urandom % 255, $urandom % 255);
		run_case(3, 2, 3, $urandom % 255, $urandom % 255);
		run_case(3, 3, 2, 255, 255);
		run_case(7, 1, 2, t, $urandom % t);
		run_case(1, 2, 3, 1 + $urandom % 254, 1 + $urandom % 254);
		run_case(5, 3, 2, t, 1 + $urandom % (t - 1));
		run_case(5, 2, 3, t, t);
		conclude();
	end
endmodule

bind timer_compare_output_control timer_compare_output_control_monitor mon_u (
	.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .compare_out_a(compare_out_a),
	.compare_out_a_sel(compare_out_a_sel), .compare_out_b(compare_out_b),
	.compare_out_b_sel(compare_out_b_sel), .irq(irq));
